// [bench/mscb_host_model.sv]
// Host model: single-byte register reads and writes
module mscb_host_model
	import mscb_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Register port
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata_q
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
	end
	// Released address and data lines show the inverse so stale values never match
	task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		@(negedge mclk);
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
		@(negedge mclk);
		q = reg_rdata_q;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
	endtask : acc
endmodule : mscb_host_model

// [bench/mscb_mode_setting_config_bank_sva.sv]
// Checker: register port and drive word relations
module mscb_sva
	import mscb_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata_q,
	input wire logic reg_hit_q,
	input wire logic [1:0] active_mode_q,
	input wire mscb_drive_t m1_drive_q,
	input wire logic m1_drive_valid_q,
	input wire mscb_drive_t m2_drive_q,
	input wire logic m2_drive_valid_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	logic mapped;
	assign mapped = reg_addr inside {8'h28, 8'h29, 8'h2a};
	sequence s_wr; clk_en && reg_wr && mapped; endsequence
	sequence s_rd; clk_en && reg_rd && mapped; endsequence
	property p_hit; (s_rd) |=> reg_hit_q; endproperty
	property p_miss; clk_en && reg_rd && !mapped |=> reg_rdata_q == 8'h00 && !reg_hit_q;
	endproperty
	property p_wr_rd;
		s_wr ##1 !(clk_en && reg_wr) ##1 (clk_en && reg_rd && reg_addr == $past(reg_addr, 2))
			|=> reg_rdata_q == $past(reg_wdata, 3);
	endproperty
	property p_keep; !(clk_en && reg_rd) |=> $stable(reg_rdata_q); endproperty
	property p_v1; m1_drive_valid_q == (active_mode_q == 2'b01); endproperty
	property p_v2; m2_drive_valid_q == (active_mode_q == 2'b10); endproperty
	property p_z1; !m1_drive_valid_q |-> m1_drive_q == '0; endproperty
	property p_z2; !m2_drive_valid_q |-> m2_drive_q == '0; endproperty
	property p_sat1; m1_drive_valid_q |-> m1_drive_q.aon_code <= MSCB_AON_CODE_MAX
		&& m1_drive_q.system_linear_code <= MSCB_SYSLIN_CODE_MAX; endproperty
	property p_sat2; m2_drive_valid_q |-> m2_drive_q.core_buck_code <= MSCB_CORE_CODE_MAX
		|| m2_drive_q.core_buck_code == MSCB_CORE_CODE_FIXED; endproperty
	a_hit: assert property (p_hit) else $error("no hit");
	a_miss: assert property (p_miss) else $error("bad miss");
	a_wr_rd: assert property (p_wr_rd) else $error("readback");
	a_keep: assert property (p_keep) else $error("rdata moved");
	a_v1: assert property (p_v1) else $error("valid1");
	a_v2: assert property (p_v2) else $error("valid2");
	a_z1: assert property (p_z1) else $error("drive1");
	a_z2: assert property (p_z2) else $error("drive2");
	a_sat1: assert property (p_sat1) else $error("sat1");
	a_sat2: assert property (p_sat2) else $error("sat2");
endmodule : mscb_sva
bind mscb_mode_setting_config_bank mscb_sva mscb_sva_inst (
	.mclk(mclk),
	.srst(srst),
	.clk_en(clk_en),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rdata_q(reg_rdata_q),
	.reg_hit_q(reg_hit_q),
	.active_mode_q(active_mode_q),
	.m1_drive_q(m1_drive_q),
	.m1_drive_valid_q(m1_drive_valid_q),
	.m2_drive_q(m2_drive_q),
	.m2_drive_valid_q(m2_drive_valid_q)
);

// [bench/mscb_mode_setting_config_bank_tb.sv]
// Testbench: register access and mode drive checks
module mscb_mode_setting_config_bank_tb import mscb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, srst = 1, clk_en = 1, reg_wr, reg_rd, reg_hit_q;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_q, q;
	logic mode_select_pin_a = 0, mode_select_pin_b = 0;
	logic mode_register_bit_a = 0, mode_register_bit_b = 0;
	logic [1:0] active_mode_q;
	logic m1_drive_valid_q, m2_drive_valid_q;
	mscb_drive_t m1_drive_q, m2_drive_q, x;
	int n_fail = 0, n_tests = 0;
	mscb_mode_setting_config_bank mscb_mode_setting_config_bank_inst (
		.mclk(mclk),
		.srst(srst),
		.clk_en(clk_en),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata_q(reg_rdata_q),
		.reg_hit_q(reg_hit_q),
		.mode_select_pin_a(mode_select_pin_a),
		.mode_select_pin_b(mode_select_pin_b),
		.mode_register_bit_a(mode_register_bit_a),
		.mode_register_bit_b(mode_register_bit_b),
		.active_mode_q(active_mode_q),
		.m1_drive_q(m1_drive_q),
		.m1_drive_valid_q(m1_drive_valid_q),
		.m2_drive_q(m2_drive_q),
		.m2_drive_valid_q(m2_drive_valid_q)
	);
	mscb_host_model mscb_host_model_inst (
		.mclk(mclk),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata_q(reg_rdata_q)
	);
	always #25 mclk = ~mclk;
	task automatic chk(input logic [$bits(mscb_drive_t)-1:0] s, e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic w(input logic [7:0] a, d);
		mscb_host_model_inst.acc(1'b1, a, d, q);
	endtask : w
	task automatic r(input logic [7:0] a, e);
		mscb_host_model_inst.acc(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask : r
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test
	initial begin
		#200000;
		n_fail++;
		end_of_test;
	end
	initial begin
		repeat (3) @(negedge mclk);
		srst = 0;
		r(8'h28, 8'h4f);
		r(8'h29, 8'h0c);
		r(8'h2a, 8'h1c);
		chk(reg_hit_q, 1'b1);
		r(8'h2b, 8'h00);
		chk(reg_hit_q, 1'b0);
		$display("test reset done");
		w(8'h28, 8'hf5);
		r(8'h28, 8'hf5);
		mode_register_bit_a = 1;
		x = '0;
		{x.aon_code, x.system_buck_en, x.system_linear_en} = {4'h8, 2'b11};
		{x.system_linear_offset, x.system_linear_code} = {1'b1, 5'h18};
		for (int i = 0; i < 4; i++) begin
			w(8'h29, {i[1:0], 6'h3f});
			@(negedge mclk);
			x.watchdog_sel = i[1:0];
			chk(m1_drive_q, x);
		end
		w(8'h28, 8'h3a);
		@(negedge mclk);
		{x.aon_code, x.core_buck_en, x.aon_en} = {4'h3, 2'b11};
		{x.system_buck_en, x.system_linear_en} = 2'b00;
		chk(m1_drive_q, x);
		$display("test mode one done");
		w(8'h2a, 8'he9);
		mode_select_pin_b = 1;
		repeat (3) @(negedge mclk);
		chk({m1_drive_valid_q, m2_drive_valid_q}, 2'b01);
		x = '0;
		{x.ship_mode, x.core_buck_code} = {1'b1, 6'h28};
		chk(m2_drive_q, x);
		w(8'h2a, 8'hff);
		@(negedge mclk);
		x.core_buck_code = 6'h3f;
		chk(m2_drive_q, x);
		w(8'h2a, 8'h3f);
		repeat (3) @(negedge mclk);
		chk(active_mode_q, 2'b01);
		clk_en = 0;
		w(8'h28, 8'h00);
		clk_en = 1;
		r(8'h28, 8'h3a);
		$display("test mode two done");
		end_of_test;
	end
endmodule : mscb_mode_setting_config_bank_tb

// [include/mscb_pkg.sv]
// Package: register map, field layout, reset values and code tables of the mode config bank
package mscb_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] MSCB_ADDR_M1_ENABLE = 8'h28;
	localparam logic [7:0] MSCB_ADDR_M1_WDOG = 8'h29;
	localparam logic [7:0] MSCB_ADDR_M2_SHIP = 8'h2a;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] MSCB_RST_M1_ENABLE = 8'h4f;
	localparam logic [7:0] MSCB_RST_M1_WDOG = 8'h0c;
	localparam logic [7:0] MSCB_RST_M2_SHIP = 8'h1c;

	// ------------------------------------------------------------
	// Code tables
	// ------------------------------------------------------------
	localparam logic [3:0] MSCB_AON_CODE_MAX = 4'h8;
	localparam logic [4:0] MSCB_SYSLIN_CODE_MAX = 5'h18;
	localparam logic [5:0] MSCB_CORE_CODE_MAX = 6'h28;
	localparam logic [5:0] MSCB_CORE_CODE_FIXED = 6'h3f;
	localparam logic [1:0] MSCB_WDOG_OFF = 2'h0;
	localparam logic [1:0] MSCB_WDOG_16S = 2'h1;
	localparam logic [1:0] MSCB_WDOG_32S = 2'h2;
	localparam logic [1:0] MSCB_WDOG_64S = 2'h3;
	// Mode codes as seen on {b, a}
	localparam logic [1:0] MSCB_MODE_ONE = 2'h1;
	localparam logic [1:0] MSCB_MODE_TWO = 2'h2;

	// ------------------------------------------------------------
	// Field layouts
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] aon_voltage_code_m1;
		logic core_buck_enable_m1;
		logic system_buck_enable_m1;
		logic aon_regulator_enable_m1;
		logic system_linear_enable_m1;
	} mscb_m1_enable_t;

	typedef struct packed {
		logic [1:0] watchdog_timeout_sel_m1;
		logic system_linear_offset_m1;
		logic [4:0] system_linear_code_m1;
	} mscb_m1_wdog_t;

	typedef struct packed {
		logic ship_mode_m2;
		logic mode_source_pin_select_m2;
		logic [5:0] core_buck_code_m2;
	} mscb_m2_ship_t;

	// Settings handed to the analog side while a mode setting is active
	typedef struct packed {
		logic core_buck_en;
		logic system_buck_en;
		logic aon_en;
		logic system_linear_en;
		logic [3:0] aon_code;
		logic system_linear_offset;
		logic [4:0] system_linear_code;
		logic [5:0] core_buck_code;
		logic [1:0] watchdog_sel;
		logic ship_mode;
	} mscb_drive_t;

endpackage : mscb_pkg

// [logic/mscb_mode_select.sv]
// Mode source select: pins or register bits, registered
module mscb_mode_select
	import mscb_pkg::*;
(
	// Clock and control
	input wire logic mclk,
	input wire logic srst,
	input wire logic clk_en,
	// Source choice
	input wire logic pin_select,
	// Mode inputs
	input wire logic mode_select_pin_a,
	input wire logic mode_select_pin_b,
	input wire logic mode_register_bit_a,
	input wire logic mode_register_bit_b,
	// Resulting mode
	output logic [1:0] mode_q
);

	logic [1:0] mode_d;

	always_comb begin
		if (pin_select) begin
			mode_d = {mode_select_pin_b, mode_select_pin_a}; // R10
		end else begin
			mode_d = {mode_register_bit_b, mode_register_bit_a}; // R10
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			mode_q <= 2'h0;
		end else if (clk_en) begin
			mode_q <= mode_d;
		end
	end

endmodule : mscb_mode_select

// [logic/mscb_mode_setting_config_bank.sv]
// Mode setting configuration bank: three host registers and the active-mode drive outputs
//
// Behaviour
// R01: Always-on regulator code, bits 7:4, reset 0100
// R02: Core buck enable mode 1, reset one
// R03: System buck enable mode 1, reset one
// R04: Always-on regulator enable mode 1, reset one
// R05: System linear enable mode 1, reset one
// R06: Watchdog timeout select mode 1, reset 00
// R07: System linear 1.2 V offset, reset zero
// R08: System linear code bits 4:0, reset 01100
// R09: Ship mode request in mode 2
// R10: Mode source: register bits or pins
// R11: Core buck code mode 2, reset 011100
// R12: Core buck code saturates; 111111 fixed
// R13: All three registers read back written
// R14: Settings drive outputs only when active
module mscb_mode_setting_config_bank
	import mscb_pkg::*;
(
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic srst,
	input wire logic clk_en,
	// Register port from the serial engine
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata_q,
	output logic reg_hit_q,
	// Mode select inputs
	input wire logic mode_select_pin_a,
	input wire logic mode_select_pin_b,
	input wire logic mode_register_bit_a,
	input wire logic mode_register_bit_b,
	// Active mode and drive to the regulators
	output logic [1:0] active_mode_q,
	output mscb_drive_t m1_drive_q,
	output logic m1_drive_valid_q,
	output mscb_drive_t m2_drive_q,
	output logic m2_drive_valid_q
);

	// ------------------------------------------------------------
	// Code saturation
	// ------------------------------------------------------------
	function automatic logic [3:0] sat_aon(input logic [3:0] c);
		sat_aon = (c > MSCB_AON_CODE_MAX) ? MSCB_AON_CODE_MAX : c; // R01
	endfunction : sat_aon

	function automatic logic [4:0] sat_syslin(input logic [4:0] c);
		sat_syslin = (c > MSCB_SYSLIN_CODE_MAX) ? MSCB_SYSLIN_CODE_MAX : c; // R08
	endfunction : sat_syslin

	// Fixed high code passes through untouched, codes above the top step clamp to it
	function automatic logic [5:0] sat_core(input logic [5:0] c);
		if (c == MSCB_CORE_CODE_FIXED) begin
			sat_core = c; // R12
		end else if (c > MSCB_CORE_CODE_MAX) begin
			sat_core = MSCB_CORE_CODE_MAX; // R12
		end else begin
			sat_core = c;
		end
	endfunction : sat_core

	// Address decode shared by the hit flag and any later users
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == MSCB_ADDR_M1_ENABLE) || (a == MSCB_ADDR_M1_WDOG)
			|| (a == MSCB_ADDR_M2_SHIP);
	endfunction : is_mapped

	function automatic logic mode_is(input logic [1:0] m, input logic [1:0] code);
		mode_is = (m == code); // R14
	endfunction : mode_is

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	mscb_m1_enable_t m1_enable_q;
	mscb_m1_wdog_t m1_wdog_q;
	mscb_m2_ship_t m2_ship_q;
	logic [1:0] mode_q;

	// ------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------
	// Strobes count only on an enabled edge, so a frozen clock drops them
	logic wr_take;
	logic rd_take;
	logic wr_m1_enable;
	logic wr_m1_wdog;
	logic wr_m2_ship;

	assign wr_take = clk_en && reg_wr;
	assign rd_take = clk_en && reg_rd;
	assign wr_m1_enable = wr_take && (reg_addr == MSCB_ADDR_M1_ENABLE);
	assign wr_m1_wdog = wr_take && (reg_addr == MSCB_ADDR_M1_WDOG);
	assign wr_m2_ship = wr_take && (reg_addr == MSCB_ADDR_M2_SHIP);

	always_ff @(posedge mclk) begin
		if (srst) begin
			m1_enable_q <= MSCB_RST_M1_ENABLE; // R01 R02 R03 R04 R05
		end else if (wr_m1_enable) begin
			m1_enable_q <= reg_wdata; // R13
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			m1_wdog_q <= MSCB_RST_M1_WDOG; // R06 R07 R08
		end else if (wr_m1_wdog) begin
			m1_wdog_q <= reg_wdata; // R13
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			m2_ship_q <= MSCB_RST_M2_SHIP; // R09 R10 R11
		end else if (wr_m2_ship) begin
			m2_ship_q <= reg_wdata; // R13
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Unmapped addresses read zero and drop hit so the engine can NACK
	always_ff @(posedge mclk) begin
		if (srst) begin
			reg_hit_q <= 1'b0;
		end else if (clk_en) begin
			reg_hit_q <= (reg_rd || reg_wr) && is_mapped(reg_addr); // R13
		end
	end

	// Data holds between reads so a slow engine can fetch it late
	always_ff @(posedge mclk) begin
		if (srst) begin
			reg_rdata_q <= 8'h00;
		end else if (rd_take) begin
			unique case (reg_addr)
				MSCB_ADDR_M1_ENABLE: reg_rdata_q <= m1_enable_q; // R13
				MSCB_ADDR_M1_WDOG: reg_rdata_q <= m1_wdog_q; // R13
				MSCB_ADDR_M2_SHIP: reg_rdata_q <= m2_ship_q; // R13
				default: reg_rdata_q <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Mode source
	// ------------------------------------------------------------
	mscb_mode_select u_mode_select (
		.mclk(mclk),
		.srst(srst),
		.clk_en(clk_en),
		.pin_select(m2_ship_q.mode_source_pin_select_m2),
		.mode_select_pin_a(mode_select_pin_a),
		.mode_select_pin_b(mode_select_pin_b),
		.mode_register_bit_a(mode_register_bit_a),
		.mode_register_bit_b(mode_register_bit_b),
		.mode_q(mode_q)
	);

	// ------------------------------------------------------------
	// Drive outputs
	// ------------------------------------------------------------
	// Only this bank's fields are known; others stay zero in the drive words
	mscb_drive_t m1_d;
	mscb_drive_t m2_d;

	always_comb begin
		m1_d = '0;
		m2_d = '0;
		if (mode_is(mode_q, MSCB_MODE_ONE)) begin
			m1_d.core_buck_en = m1_enable_q.core_buck_enable_m1; // R02
			m1_d.system_buck_en = m1_enable_q.system_buck_enable_m1; // R03
			m1_d.aon_en = m1_enable_q.aon_regulator_enable_m1; // R04
			m1_d.system_linear_en = m1_enable_q.system_linear_enable_m1; // R05
			m1_d.aon_code = sat_aon(m1_enable_q.aon_voltage_code_m1); // R01
			m1_d.watchdog_sel = m1_wdog_q.watchdog_timeout_sel_m1; // R06
			m1_d.system_linear_offset = m1_wdog_q.system_linear_offset_m1; // R07
			m1_d.system_linear_code = sat_syslin(m1_wdog_q.system_linear_code_m1); // R08
		end
		if (mode_is(mode_q, MSCB_MODE_TWO)) begin
			m2_d.ship_mode = m2_ship_q.ship_mode_m2; // R09
			m2_d.core_buck_code = sat_core(m2_ship_q.core_buck_code_m2); // R11 R12
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			m1_drive_q <= '0;
		end else if (clk_en) begin
			m1_drive_q <= m1_d; // R14
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			m2_drive_q <= '0;
		end else if (clk_en) begin
			m2_drive_q <= m2_d; // R14
		end
	end

	// Valid flags follow the same edge as the drive words they qualify
	always_ff @(posedge mclk) begin
		if (srst) begin
			m1_drive_valid_q <= 1'b0;
			m2_drive_valid_q <= 1'b0;
		end else if (clk_en) begin
			m1_drive_valid_q <= mode_is(mode_q, MSCB_MODE_ONE); // R14
			m2_drive_valid_q <= mode_is(mode_q, MSCB_MODE_TWO); // R14
		end
	end

	// Reported mode lines up with the valid flags
	always_ff @(posedge mclk) begin
		if (srst) begin
			active_mode_q <= 2'h0;
		end else if (clk_en) begin
			active_mode_q <= mode_q; // R10
		end
	end

endmodule : mscb_mode_setting_config_bank
